// [hw/gfp_global_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "gfp_map.vh"

module gfp_global_regs #(
    parameter [63:0] NORMAL_AGE_CYCLES = `GFP_NORMAL_AGE_CYCLES,
    parameter [63:0] FAST_AGE_CYCLES = `GFP_FAST_AGE_CYCLES
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire mac_mode_strap_pin_i,
    input wire switch_mii_rx_bit0_strap_i,
    input wire [47:0] destination_address_i,
    output reg [7:0] ctrl_one_o,
    output reg [7:0] ctrl_two_o,
    output reg pass_all_frames_o,
    output reg repeater_mode_o,
    output reg tx_flow_ctrl_en_o,
    output reg rx_flow_ctrl_en_o,
    output reg len_field_check_o,
    output reg [15:0] len_field_limit_o,
    output reg aggressive_backoff_o,
    output reg vlan_cross_block_o,
    output reg storm_regulate_o,
    output reg carrier_backpressure_o,
    output reg fair_mode_o,
    output reg excess_collision_drop_o,
    output reg [4:0] collision_limit_o,
    output reg [10:0] max_len_tagged_o,
    output reg [10:0] max_len_untagged_o,
    output reg [5:0] hp_reserved_buffers_o,
    output reg age_tick_o,
    output reg fast_age_active_o
);

////////////////////////////////////////////////////////////////////////////////
// register file

reg [7:0] ctrl_one;
reg [7:0] ctrl_two;
reg strap_pending;
reg fast_done;
reg [63:0] age_count;
reg [7:0] next_ctrl_one;
reg [7:0] next_ctrl_two;

wire wr_one = reg_wr_i && (reg_addr_i == `GFP_ADDR_CTRL_ONE);
wire wr_two = reg_wr_i && (reg_addr_i == `GFP_ADDR_CTRL_TWO);

always @* begin
    next_ctrl_one = ctrl_one;
    next_ctrl_two = ctrl_two;
    // end of a fast cycle drops back to normal aging
    if (fast_done) begin
        next_ctrl_one[`GFP_B_FAST_AGE] = 1'b0;
    end
    if (wr_one) begin
        next_ctrl_one = reg_wdata_i;
    end
    if (wr_two) begin
        next_ctrl_two = reg_wdata_i;
    end
    // straps taken on the first edge after release
    if (strap_pending) begin
        next_ctrl_one[`GFP_B_AGGR_BACKOFF] = mac_mode_strap_pin_i;
        next_ctrl_two[`GFP_B_NO_EXC_DROP] = mac_mode_strap_pin_i;
        next_ctrl_two[`GFP_B_LEGAL_MAX] = switch_mii_rx_bit0_strap_i;
    end
end

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        ctrl_one <= `GFP_RST_CTRL_ONE;
        ctrl_two <= `GFP_RST_CTRL_TWO;
        strap_pending <= 1'b1;
    end else begin
        ctrl_one <= next_ctrl_one;
        ctrl_two <= next_ctrl_two;
        strap_pending <= 1'b0;
    end
end

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
        case (reg_addr_i)
            `GFP_ADDR_CTRL_ONE: reg_rdata_o <= ctrl_one;
            `GFP_ADDR_CTRL_TWO: reg_rdata_o <= ctrl_two;
            default: reg_rdata_o <= 8'h00;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// aging timer

wire aging_on = ctrl_one[`GFP_B_AGING];
wire fast_on = ctrl_one[`GFP_B_FAST_AGE];
wire [63:0] period = fast_on ? FAST_AGE_CYCLES : NORMAL_AGE_CYCLES;
wire period_end = (age_count + 64'h1 >= period);

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        age_count <= 64'h0;
        age_tick_o <= 1'b0;
        fast_done <= 1'b0;
    end else if (!aging_on || fast_done) begin
        age_count <= 64'h0;
        age_tick_o <= 1'b0;
        fast_done <= 1'b0;
    end else if (period_end) begin
        age_count <= 64'h0;
        age_tick_o <= 1'b1;
        fast_done <= fast_on;
    end else begin
        age_count <= age_count + 64'h1;
        age_tick_o <= 1'b0;
        fast_done <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// policy outputs

wire bcast = &destination_address_i;
wire mcast = destination_address_i[40];

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        ctrl_one_o <= `GFP_RST_CTRL_ONE;
        ctrl_two_o <= `GFP_RST_CTRL_TWO;
        pass_all_frames_o <= 1'b0;
        repeater_mode_o <= 1'b0;
        tx_flow_ctrl_en_o <= 1'b1;
        rx_flow_ctrl_en_o <= 1'b1;
        len_field_check_o <= 1'b0;
        len_field_limit_o <= `GFP_LEN_FIELD_LIMIT;
        aggressive_backoff_o <= 1'b0;
        vlan_cross_block_o <= 1'b1;
        storm_regulate_o <= 1'b0;
        carrier_backpressure_o <= 1'b1;
        fair_mode_o <= 1'b1;
        excess_collision_drop_o <= 1'b1;
        collision_limit_o <= `GFP_COLLISION_LIMIT;
        max_len_tagged_o <= `GFP_LEN_DEFAULT;
        max_len_untagged_o <= `GFP_LEN_DEFAULT;
        hp_reserved_buffers_o <= `GFP_HP_BUFFERS;
        fast_age_active_o <= 1'b0;
    end else begin
        ctrl_one_o <= ctrl_one;
        ctrl_two_o <= ctrl_two;
        pass_all_frames_o <= ctrl_one[`GFP_B_PASS_ALL];
        repeater_mode_o <= ctrl_one[`GFP_B_REPEATER];
        tx_flow_ctrl_en_o <= ctrl_one[`GFP_B_TX_FC];
        rx_flow_ctrl_en_o <= ctrl_one[`GFP_B_RX_FC];
        len_field_check_o <= ctrl_one[`GFP_B_LEN_CHECK];
        len_field_limit_o <= `GFP_LEN_FIELD_LIMIT;
        aggressive_backoff_o <= ctrl_one[`GFP_B_AGGR_BACKOFF];
        vlan_cross_block_o <= ctrl_two[`GFP_B_VLAN_DISCARD];
        storm_regulate_o <= bcast || (!ctrl_two[`GFP_B_MCAST_STORM_OFF] && mcast);
        carrier_backpressure_o <= ctrl_two[`GFP_B_BP_CARRIER];
        fair_mode_o <= ctrl_two[`GFP_B_FAIR];
        excess_collision_drop_o <= !ctrl_two[`GFP_B_NO_EXC_DROP];
        collision_limit_o <= `GFP_COLLISION_LIMIT;
        if (ctrl_two[`GFP_B_HUGE]) begin
            max_len_tagged_o <= `GFP_LEN_HUGE;
            max_len_untagged_o <= `GFP_LEN_HUGE;
        end else if (ctrl_two[`GFP_B_LEGAL_MAX]) begin
            max_len_tagged_o <= `GFP_LEN_TAGGED;
            max_len_untagged_o <= `GFP_LEN_UNTAGGED;
        end else begin
            max_len_tagged_o <= `GFP_LEN_DEFAULT;
            max_len_untagged_o <= `GFP_LEN_DEFAULT;
        end
        hp_reserved_buffers_o <= ctrl_two[`GFP_B_PRIO_RESERVE] ? `GFP_HP_BUFFERS : 6'h00;
        fast_age_active_o <= aging_on && fast_on;
    end
end

endmodule // gfp_global_regs

`default_nettype wire

// [hw/gfp_map.vh]
// Overview of operation
// - bit 7 of control one forwards all frames, bad included, with sniffer mode.
// - bit 6 of control one selects normal switching or half-duplex hub repeater.
// - bit 5 of control one enables transmit 802.3x flow control; resets to 1.
// - bit 4 of control one enables receive 802.3x flow control; resets to 1.
// - bit 3 of control one drops frames whose length field below 1500 mismatches.
// - bit 2 of control one enables address-table aging; resets to 1.
// - bit 1 of control one selects fast aging with roughly 800us period.
// - bit 0 of control one enables aggressive back-off; reset from mac-mode strap.
// - bit 7 of control two blocks VLAN crossing; clear lets known unicast cross.
// - bit 6 of control two limits storm control to broadcast; clear adds multicast.
// - bit 5 of control two picks carrier-sense (1) or collision backpressure; resets 1.
// - bit 4 of control two fair mode drops non-flow-controlled port packets.
// - bit 3 of control two retries after 16 collisions, else drops; strapped.
// - bit 2 of control two accepts up to 1916 bytes, overriding bit 1.
// - bit 1 of control two: 1536 limit, or 1522 tagged/1518 untagged; strapped.
// - bit 0 of control two reserves 48 buffers per queue for high priority.
// - normal aging period about 200 s; after a fast cycle return to it.
`ifndef GFP_MAP_VH
`define GFP_MAP_VH

`define GFP_ADDR_CTRL_ONE 8'h03
`define GFP_ADDR_CTRL_TWO 8'h04

// control one fields
`define GFP_B_PASS_ALL 7
`define GFP_B_REPEATER 6
`define GFP_B_TX_FC 5
`define GFP_B_RX_FC 4
`define GFP_B_LEN_CHECK 3
`define GFP_B_AGING 2
`define GFP_B_FAST_AGE 1
`define GFP_B_AGGR_BACKOFF 0

// control two fields
`define GFP_B_VLAN_DISCARD 7
`define GFP_B_MCAST_STORM_OFF 6
`define GFP_B_BP_CARRIER 5
`define GFP_B_FAIR 4
`define GFP_B_NO_EXC_DROP 3
`define GFP_B_HUGE 2
`define GFP_B_LEGAL_MAX 1
`define GFP_B_PRIO_RESERVE 0

// reset values, strap bits shown as zero
`define GFP_RST_CTRL_ONE 8'h34
`define GFP_RST_CTRL_TWO 8'hF1

`define GFP_LEN_FIELD_LIMIT 16'h05DC
`define GFP_LEN_HUGE 11'h77C
`define GFP_LEN_DEFAULT 11'h600
`define GFP_LEN_TAGGED 11'h5F2
`define GFP_LEN_UNTAGGED 11'h5EE
`define GFP_HP_BUFFERS 6'h30
`define GFP_COLLISION_LIMIT 5'h10

`define GFP_CLK_HZ 100000000
`define GFP_FAST_AGE_US 800
`define GFP_NORMAL_AGE_S 200
`define GFP_FAST_AGE_CYCLES (64'd800 * 64'd100000000 / 64'd1000000)
`define GFP_NORMAL_AGE_CYCLES (64'd200 * 64'd100000000)

`endif

// [tb/gfp_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module gfp_regs_sva (
    input wire clk_i,
    input wire arst_n_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire [7:0] ctrl_one_o,
    input wire [7:0] ctrl_two_o,
    input wire excess_collision_drop_o,
    input wire [10:0] max_len_tagged_o,
    input wire [5:0] hp_reserved_buffers_o,
    input wire age_tick_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_write_one: assert property (reg_wr_i && reg_addr_i == 8'h03 |-> ##2
        ctrl_one_o[7:2] == $past(reg_wdata_i[7:2], 2)) else $error("control one write lost");
    a_write_two: assert property (reg_wr_i && reg_addr_i == 8'h04 |-> ##2
        ((ctrl_two_o ^ $past(reg_wdata_i, 2)) & 8'hF5) == 8'h00) else $error("control two write lost");
    a_read_one: assert property (reg_rd_i && reg_addr_i == 8'h03 |=> reg_rdata_o == ctrl_one_o)
        else $error("control one read wrong");
    a_read_two: assert property (reg_rd_i && reg_addr_i == 8'h04 |=> reg_rdata_o == ctrl_two_o)
        else $error("control two read wrong");
    a_read_unmapped: assert property (reg_rd_i && reg_addr_i != 8'h03 && reg_addr_i != 8'h04
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    a_excess_drop: assert property (excess_collision_drop_o == !ctrl_two_o[3]) else $error("drop wrong");
    a_size_limit: assert property (max_len_tagged_o == (ctrl_two_o[2] ? 11'h77C :
        ctrl_two_o[1] ? 11'h5F2 : 11'h600)) else $error("size limit wrong");
    a_hp_reserve: assert property (hp_reserved_buffers_o == (ctrl_two_o[0] ? 6'h30 : 6'h00))
        else $error("reserve wrong");
    a_tick_pulse: assert property (age_tick_o |=> !age_tick_o) else $error("tick too long");
    c_wr_two: cover property (reg_wr_i && reg_addr_i == 8'h04);
    c_tick: cover property (age_tick_o);
    c_huge: cover property (ctrl_two_o[2]);
endmodule // gfp_regs_sva
bind gfp_global_regs gfp_regs_sva u_sva (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ctrl_one_o(ctrl_one_o), .ctrl_two_o(ctrl_two_o), .excess_collision_drop_o(excess_collision_drop_o),
    .max_len_tagged_o(max_len_tagged_o), .hp_reserved_buffers_o(hp_reserved_buffers_o), .age_tick_o(age_tick_o));
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_rd_i = 1'b0;
    logic m_strap = 1'b0;
    logic r_strap = 1'b0;
    logic [47:0] dst = 48'h0;
    wire p_all, rep, txf, rxf, lenc, aggr, vlan, storm, csbp, fair, exd, tick, fast;
    wire [7:0] rdata, c1, c2;
    wire [10:0] ml_t, ml_u;
    wire [15:0] lfl;
    wire [4:0] cl;
    wire [5:0] hp;
    int n_fail = 0;
    int n_checks = 0;
    int k, n;
    logic [7:0] d;
    always #5 clk_i = ~clk_i;
    gfp_global_regs #(.NORMAL_AGE_CYCLES(64'd100), .FAST_AGE_CYCLES(64'd20)) i_dut (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .mac_mode_strap_pin_i(m_strap),
        .switch_mii_rx_bit0_strap_i(r_strap), .destination_address_i(dst), .ctrl_one_o(c1), .ctrl_two_o(c2),
        .pass_all_frames_o(p_all), .repeater_mode_o(rep), .tx_flow_ctrl_en_o(txf), .rx_flow_ctrl_en_o(rxf),
        .len_field_check_o(lenc), .len_field_limit_o(lfl), .aggressive_backoff_o(aggr),
        .vlan_cross_block_o(vlan), .storm_regulate_o(storm), .carrier_backpressure_o(csbp), .fair_mode_o(fair),
        .excess_collision_drop_o(exd), .collision_limit_o(cl), .max_len_tagged_o(ml_t), .max_len_untagged_o(ml_u),
        .hp_reserved_buffers_o(hp), .age_tick_o(tick), .fast_age_active_o(fast));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = v;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        chk(rdata & m, e & m);
    endtask
    function automatic logic [31:0] pol2(input logic [7:0] v);
        return {v[7], v[5], v[4], ~v[3], v[2] ? 11'h77C : v[1] ? 11'h5F2 : 11'h600,
            v[2] ? 11'h77C : v[1] ? 11'h5EE : 11'h600, v[0] ? 6'h30 : 6'h00};
    endfunction
    // write, then check policy outputs and read-back
    task automatic wpol(input logic [7:0] a, input logic [7:0] v);
        wr(a, v);
        repeat (2) @(negedge clk_i);
        if (a == 8'h03) chk({p_all, rep, txf, rxf, lenc, aggr}, {v[7:3], v[0]});
        else chk({vlan, csbp, fair, exd, ml_t, ml_u, hp}, pol2(v));
        rd(a, v, a == 8'h03 ? 8'hFD : 8'hFF);
    endtask
    task automatic tick_gap();
        n = 0;
        while (tick !== 1'b1 && n < 500) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 500) begin
            n_fail++;
            $display("CHECK FAILED t=%0t no aging tick", $time);
            finish_test;
        end
    endtask
    task finish_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(15685));
        m_strap = 1'($urandom);
        r_strap = 1'($urandom);
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) arst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        rd(8'h03, {7'h1A, m_strap}, 8'hFF);
        rd(8'h04, {4'hF, m_strap, 1'b0, r_strap, 1'b1}, 8'hFF);
        chk({lfl, cl}, {16'h05DC, 5'h10});
        for (k = 0; k < 4; k++) wpol(8'h04, 8'(k * 2));
        for (k = 0; k < 24; k++) wpol(k[0] ? 8'h04 : 8'h03, 8'($urandom));
        d = c2;
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00, 8'hFF);
        chk(c2, d);
        for (k = 0; k < 8; k++) begin
            wr(8'h04, {1'b1, k[0], 6'h31});
            dst = k[1] ? 48'hFFFF_FFFF_FFFF : {7'h0, k[2], 40'h1};
            repeat (3) @(negedge clk_i);
            chk(storm, k[1] | (k[2] & ~k[0]));
        end
        wr(8'h03, 8'h00);
        n = 0;
        repeat (150) begin
            @(negedge clk_i);
            n += int'(tick);
        end
        chk(n, 0);
        wr(8'h03, 8'h06);
        @(negedge clk_i);
        chk(32'(fast), 1);
        tick_gap();
        chk(32'(n >= 14 && n <= 24), 1);
        @(negedge clk_i);
        tick_gap();
        chk(32'(n >= 95 && n <= 106), 1);
        rd(8'h03, 8'h04, 8'hFE);
        chk(32'(fast), 0);
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        finish_test;
    end
endmodule // testbench
`default_nettype wire
